/* miml_pkg.sv */
// Constants shared by the monitor interrupt and mask block.
// Assumes a single 100 MHz clock and a host port giving byte-wide access.
package miml_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG     = 8'h40;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
	localparam logic [7:0] ADDR_MGMT_ONE   = 8'h43;
	localparam logic [7:0] ADDR_MGMT_TWO   = 8'h44;
	localparam logic [7:0] ADDR_HOST_ONE   = 8'h45;
	localparam logic [7:0] ADDR_HOST_TWO   = 8'h46;
	localparam logic [7:0] ADDR_VID_DIV    = 8'h47;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CONFIG_RST   = 8'h08;
	localparam logic [7:0] STATUS_RST   = 8'h00;
	localparam logic [7:0] MASK_RST     = 8'h00;
	localparam logic [7:0] HOST_TWO_RST = 8'h40;
	localparam logic [3:0] DIV_HI_RST   = 4'h5;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_MGMT_EN   = 1;
	localparam int CFG_HOST_EN   = 2;
	localparam int CFG_INT_CLEAR = 3;
	localparam int CFG_RESET     = 4;
	localparam int CFG_NMI_SEL   = 5;
	localparam int CFG_BYPASS    = 6;
	localparam int CFG_INIT      = 7;
	localparam int ST2_CHASSIS   = 4;
	localparam int ST2_FIFO      = 5;
	localparam int ST2_CHAIN     = 6;
	localparam int MGMT2_PERMIT  = 7;
	localparam int HOST2_CLEAR   = 7;
	localparam int SOURCES       = 15;

	// Prescaler select codes and divide factors
	localparam logic [1:0] DIV_SEL_1  = 2'h0;
	localparam logic [1:0] DIV_SEL_2  = 2'h1;
	localparam logic [1:0] DIV_SEL_4  = 2'h2;
	localparam logic [3:0] DIV_BY_1   = 4'h1;
	localparam logic [3:0] DIV_BY_2   = 4'h2;
	localparam logic [3:0] DIV_BY_4   = 4'h4;
	localparam logic [3:0] DIV_BY_8   = 4'h8;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLOCK_KHZ    = 100000;
	localparam int unsigned PULSE_MS     = 20;
	localparam int unsigned PULSE_CYCLES = PULSE_MS * CLOCK_KHZ;
	localparam int unsigned POST_DEPTH   = 32;

	typedef enum logic [0:0] {
		MIML_IDLE  = 1'b0,
		MIML_PULSE = 1'b1
	} miml_pulse_state_t;

endpackage : miml_pkg

/* miml_pulse_timer.sv */
// Timed pulse generator: start launches a high active_out pulse of CYCLES clocks.
// Assumes start is a same-clock strobe; starts while busy are ignored.
module miml_pulse_timer #(
	parameter int unsigned CYCLES = miml_pkg::PULSE_CYCLES
) (
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic start_in,
	output logic      active_out,
	output logic      done_out
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	miml_pkg::miml_pulse_state_t state;
	logic [W-1:0]                count;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state      <= miml_pkg::MIML_IDLE;
			count      <= '0;
			active_out <= 1'b0;
			done_out   <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state)
				miml_pkg::MIML_IDLE: begin
					count <= '0;
					if (start_in) begin
						state      <= miml_pkg::MIML_PULSE;
						active_out <= 1'b1;
					end
				end
				miml_pkg::MIML_PULSE: begin
					if (count == LAST) begin
						state      <= miml_pkg::MIML_IDLE;
						active_out <= 1'b0;
						done_out   <= 1'b1;
					end else begin
						count <= count + 1'b1;
					end
				end
				default: begin
					state      <= miml_pkg::MIML_IDLE;
					active_out <= 1'b0;
				end
			endcase
		end
	end

	// Pulse never ends short of its programmed length
	a_pulse_length: assert property (@(posedge clock_in) disable iff (rst_in)
		$fell(active_out) |-> $past(count) == LAST)
		else $error("pulse ended early");
	a_done_follows: assert property (@(posedge clock_in) disable iff (rst_in)
		done_out |-> !active_out && $past(active_out))
		else $error("done without pulse end");

endmodule : miml_pulse_timer

/* miml_top.sv */
// Interrupt status, mask, pulse control and divisor registers of the
// hardware monitor. Assumes limit and tach alarm strobes come from logic on
// clock_in; pins pass a two-stage synchroniser first.
// Summary of operation
// - Status two bits 0-2 set on channel 4, 5, 6 limit alarms.
// - Status two bit 3 sets when tachometer 3 passes its count limit.
// - Status two bit 4 sets while the intrusion input is high, except during the clear pulse.
// - Status two bit 5 sets on the 32nd POST buffer write.
// - Status two bit 6 sets on chained input falling; bit 7 reads zero.
// - A one in management masks blocks that status bit from its output.
// - A one in host masks blocks that status bit from the host output.
// - Masks reset to zero except host mask two bit 6, which is one.
// - Management mask two bit 7 permits the configuration reset pulse.
// - Host mask two bit 7 drives a 20 ms low intrusion pulse, self clears.
// - Divisor register low nibble shows voltage ID pins; high nibble resets to 0101.
// - Bits 5:4 pick tachometer 1 divide by 1, 2, 4 or 8.
// - Bits 7:6 pick tachometer 2 divide by 1, 2, 4 or 8.
// - Status one maps channels 0-3, temperature, overtemp, tach 1, tach 2.
// - Permitted configuration reset bit gives 20 ms low reset, then clears.
// - Config bits 1 and 2 enable outputs; bit 5 selects NMI or IRQ.
module miml_top #(
	parameter int unsigned PULSE_CYCLES = miml_pkg::PULSE_CYCLES,
	parameter int unsigned POST_DEPTH   = miml_pkg::POST_DEPTH
) (
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	input  wire logic [4:0] pos_alarm_in,
	input  wire logic [1:0] neg_alarm_in,
	input  wire logic       temp_alarm_in,
	input  wire logic [2:0] tach_alarm_in,
	input  wire logic       post_wr_in,
	input  wire logic       board_overtemp_input_n_in,
	input  wire logic       chained_mgmt_irq_pin_n_in,
	input  wire logic [3:0] voltage_id_inputs_in,
	input  wire logic       intrusion_in,
	output logic            intrusion_out,
	output logic            intrusion_oe_out,
	output logic            mgmt_irq_output_n_out,
	output logic            host_irq_n_out,
	output logic            host_irq_is_nmi_out,
	output logic            reset_n_out,
	output logic            bypass_n_out,
	output logic      [1:0] tach1_prescale_select_out,
	output logic      [1:0] tach2_prescale_select_out,
	output logic      [3:0] tach1_divisor_out,
	output logic      [3:0] tach2_divisor_out
);
	localparam int PW = $clog2(POST_DEPTH);
	localparam logic [PW-1:0] POST_LAST = PW'(POST_DEPTH - 1);

	logic [7:0]    config_reg, status_one, status_two, set_one, set_two;
	logic [7:0]    mgmt_one, mgmt_two, host_one, host_two;
	logic [3:0]    div_hi, vid_s1, vid_s2;
	logic [PW-1:0] post_ptr;
	logic [1:0]    bti_sync, chain_sync, intr_sync;
	logic          init_req, soft_rst, chain_prev;
	logic          wr_cfg, wr_host_two, rd_st_one, rd_st_two;
	logic          chassis_start, chassis_active, chassis_done;
	logic          reset_start, reset_active, reset_done;
	logic [14:0]   pend_vec, mgmt_vec, host_vec;
	logic          next_mgmt_irq, next_host_irq;

	assign soft_rst    = rst_in | init_req;
	assign wr_cfg      = reg_wr_in && reg_addr_in == miml_pkg::ADDR_CONFIG;
	assign wr_host_two = reg_wr_in && reg_addr_in == miml_pkg::ADDR_HOST_TWO;
	assign rd_st_one   = reg_rd_in && reg_addr_in == miml_pkg::ADDR_STATUS_ONE;
	assign rd_st_two   = reg_rd_in && reg_addr_in == miml_pkg::ADDR_STATUS_TWO;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			bti_sync   <= 2'h3;
			chain_sync <= 2'h3;
			intr_sync  <= 2'h0;
			vid_s1     <= 4'h0;
			vid_s2     <= 4'h0;
			chain_prev <= 1'b1;
		end else begin
			bti_sync   <= {bti_sync[0], board_overtemp_input_n_in};
			chain_sync <= {chain_sync[0], chained_mgmt_irq_pin_n_in};
			intr_sync  <= {intr_sync[0], intrusion_in};
			vid_s1     <= voltage_id_inputs_in;
			vid_s2     <= vid_s1;
			chain_prev <= chain_sync[1];
		end
	end

	// ----------------------------------------------------------------
	// Status sources
	// ----------------------------------------------------------------
	always_comb begin
		set_one = {tach_alarm_in[1:0], ~bti_sync[1], temp_alarm_in,
			pos_alarm_in[3:0]};
		set_two = 8'h00;
		set_two[2:0] = {neg_alarm_in, pos_alarm_in[4]};
		set_two[3] = tach_alarm_in[2];
		// Our own clear pulse pulls the pin low, so the level is ignored then
		set_two[miml_pkg::ST2_CHASSIS] = intr_sync[1] & ~chassis_active;
		set_two[miml_pkg::ST2_FIFO] = post_wr_in && post_ptr == POST_LAST;
		set_two[miml_pkg::ST2_CHAIN] = chain_prev & ~chain_sync[1];
	end

	// Reading a status register clears it; a set in the same cycle wins
	always_ff @(posedge clock_in) begin
		if (soft_rst) begin
			status_one <= miml_pkg::STATUS_RST;
			status_two <= miml_pkg::STATUS_RST;
		end else begin
			status_one <= (rd_st_one ? 8'h00 : status_one) | set_one;
			status_two <= (rd_st_two ? 8'h00 : status_two) | set_two;
		end
	end

	// POST write pointer stops at the last location
	always_ff @(posedge clock_in) begin
		if (soft_rst) begin
			post_ptr <= '0;
		end else if (post_wr_in && post_ptr != POST_LAST) begin
			post_ptr <= post_ptr + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Configuration and mask registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (soft_rst) begin
			init_req <= 1'b0;
		end else begin
			init_req <= wr_cfg & reg_wdata_in[miml_pkg::CFG_INIT];
		end
	end

	always_ff @(posedge clock_in) begin
		if (soft_rst) begin
			config_reg <= miml_pkg::CONFIG_RST;
		end else if (wr_cfg) begin
			config_reg <= reg_wdata_in;
			config_reg[miml_pkg::CFG_INIT] <= 1'b0;
			if (reset_active) begin
				config_reg[miml_pkg::CFG_RESET] <= 1'b1;
			end
		end else if (reset_done) begin
			config_reg[miml_pkg::CFG_RESET] <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (soft_rst) begin
			mgmt_one <= miml_pkg::MASK_RST;
			mgmt_two <= miml_pkg::MASK_RST;
			host_one <= miml_pkg::MASK_RST;
			div_hi   <= miml_pkg::DIV_HI_RST;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				miml_pkg::ADDR_MGMT_ONE: mgmt_one <= reg_wdata_in;
				miml_pkg::ADDR_MGMT_TWO: mgmt_two <= reg_wdata_in;
				miml_pkg::ADDR_HOST_ONE: host_one <= reg_wdata_in;
				miml_pkg::ADDR_VID_DIV:  div_hi   <= reg_wdata_in[7:4];
				default: begin
				end
			endcase
		end
	end

	// Clear bit stays set for the pulse, then drops by itself
	always_ff @(posedge clock_in) begin
		if (soft_rst) begin
			host_two <= miml_pkg::HOST_TWO_RST;
		end else if (wr_host_two) begin
			host_two <= reg_wdata_in;
			if (chassis_active) begin
				host_two[miml_pkg::HOST2_CLEAR] <= 1'b1;
			end
		end else if (chassis_done) begin
			host_two[miml_pkg::HOST2_CLEAR] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pulse timers
	// ----------------------------------------------------------------
	assign chassis_start = host_two[miml_pkg::HOST2_CLEAR] & ~chassis_active
		& ~chassis_done;
	assign reset_start = config_reg[miml_pkg::CFG_RESET]
		& mgmt_two[miml_pkg::MGMT2_PERMIT] & ~reset_active
		& ~reset_done;

	miml_pulse_timer #(.CYCLES(PULSE_CYCLES)) u_chassis (
		.clock_in(clock_in), .rst_in(rst_in), .start_in(chassis_start),
		.active_out(chassis_active), .done_out(chassis_done));

	miml_pulse_timer #(.CYCLES(PULSE_CYCLES)) u_reset (
		.clock_in(clock_in), .rst_in(rst_in), .start_in(reset_start),
		.active_out(reset_active), .done_out(reset_done));

	// ----------------------------------------------------------------
	// Interrupt outputs
	// ----------------------------------------------------------------
	always_comb begin
		pend_vec = {status_two[6:0], status_one};
		mgmt_vec = pend_vec & ~{mgmt_two[6:0], mgmt_one};
		host_vec = pend_vec & ~{host_two[6:0], host_one};
		next_mgmt_irq = config_reg[miml_pkg::CFG_MGMT_EN]
			& ~config_reg[miml_pkg::CFG_INT_CLEAR] & (|mgmt_vec);
		next_host_irq = config_reg[miml_pkg::CFG_HOST_EN]
			& ~config_reg[miml_pkg::CFG_INT_CLEAR] & (|host_vec);
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mgmt_irq_output_n_out <= 1'b1;
			host_irq_n_out        <= 1'b1;
			host_irq_is_nmi_out   <= 1'b0;
			intrusion_out         <= 1'b0;
			intrusion_oe_out      <= 1'b0;
			reset_n_out           <= 1'b1;
			bypass_n_out          <= 1'b1;
		end else begin
			mgmt_irq_output_n_out <= ~next_mgmt_irq;
			host_irq_n_out        <= ~next_host_irq;
			host_irq_is_nmi_out   <= config_reg[miml_pkg::CFG_NMI_SEL];
			intrusion_out         <= 1'b0;
			intrusion_oe_out      <= chassis_active;
			reset_n_out           <= ~reset_active;
			bypass_n_out          <= ~config_reg[miml_pkg::CFG_BYPASS];
		end
	end

	// ----------------------------------------------------------------
	// Tach prescalers
	// ----------------------------------------------------------------
	function automatic logic [3:0] miml_div(input logic [1:0] sel);
		case (sel)
			miml_pkg::DIV_SEL_1: miml_div = miml_pkg::DIV_BY_1;
			miml_pkg::DIV_SEL_2: miml_div = miml_pkg::DIV_BY_2;
			miml_pkg::DIV_SEL_4: miml_div = miml_pkg::DIV_BY_4;
			default:             miml_div = miml_pkg::DIV_BY_8;
		endcase
	endfunction : miml_div

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			tach1_prescale_select_out <= miml_pkg::DIV_SEL_1;
			tach2_prescale_select_out <= miml_pkg::DIV_SEL_1;
			tach1_divisor_out         <= miml_pkg::DIV_BY_1;
			tach2_divisor_out         <= miml_pkg::DIV_BY_1;
		end else begin
			tach1_prescale_select_out <= div_hi[1:0];
			tach2_prescale_select_out <= div_hi[3:2];
			tach1_divisor_out         <= miml_div(div_hi[1:0]);
			tach2_divisor_out         <= miml_div(div_hi[3:2]);
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			reg_rdata_out <= miml_pkg::READ_ZERO;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				miml_pkg::ADDR_CONFIG:     reg_rdata_out <= config_reg;
				miml_pkg::ADDR_STATUS_ONE: reg_rdata_out <= status_one;
				miml_pkg::ADDR_STATUS_TWO:
					reg_rdata_out <= {1'b0, status_two[6:0]};
				miml_pkg::ADDR_MGMT_ONE:   reg_rdata_out <= mgmt_one;
				miml_pkg::ADDR_MGMT_TWO:   reg_rdata_out <= mgmt_two;
				miml_pkg::ADDR_HOST_ONE:   reg_rdata_out <= host_one;
				miml_pkg::ADDR_HOST_TWO:   reg_rdata_out <= host_two;
				miml_pkg::ADDR_VID_DIV:
					reg_rdata_out <= {div_hi, vid_s2};
				default:                   reg_rdata_out <= miml_pkg::READ_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_clear_write;
		wr_host_two && reg_wdata_in[miml_pkg::HOST2_CLEAR] && !chassis_active
			&& !soft_rst;
	endsequence

	sequence s_clear_pulse;
		##3 intrusion_oe_out [*8];
	endsequence

	a_alarm_sets: assert property (@(posedge clock_in) disable iff (soft_rst)
		pos_alarm_in[4] |=> status_two[0])
		else $error("channel 4 alarm not latched");
	a_tach_sets: assert property (@(posedge clock_in) disable iff (soft_rst)
		tach_alarm_in[2] |=> status_two[3])
		else $error("tach 3 alarm not latched");
	a_fifo_overflow: assert property (@(posedge clock_in) disable iff (soft_rst)
		post_wr_in && post_ptr == POST_LAST |=> status_two[5])
		else $error("overflow not flagged");
	a_reserved_zero: assert property (@(posedge clock_in) disable iff (rst_in)
		$past(reg_rd_in && reg_addr_in == miml_pkg::ADDR_STATUS_TWO)
		|-> !reg_rdata_out[7])
		else $error("reserved status bit read as one");
	a_mgmt_masked: assert property (@(posedge clock_in) disable iff (rst_in)
		(mgmt_vec == '0) |=> mgmt_irq_output_n_out)
		else $error("masked status drove management output");
	a_host_masked: assert property (@(posedge clock_in) disable iff (rst_in)
		(host_vec == '0) |=> host_irq_n_out)
		else $error("masked status drove host output");
	a_reset_permit: assert property (@(posedge clock_in) disable iff (rst_in)
		$fell(reset_n_out) |-> $past(mgmt_two[miml_pkg::MGMT2_PERMIT], 2))
		else $error("reset pulse without permission");
	a_clear_pulse: assert property (@(posedge clock_in) disable iff (rst_in)
		s_clear_write |-> s_clear_pulse)
		else $error("intrusion clear pulse missing");
	a_irq_asserts: assert property (@(posedge clock_in) disable iff (rst_in)
		next_mgmt_irq |=> !mgmt_irq_output_n_out)
		else $error("management output not asserted");
	a_int_clear: assert property (@(posedge clock_in) disable iff (rst_in)
		config_reg[miml_pkg::CFG_INT_CLEAR] |=> host_irq_n_out)
		else $error("host output active while disabled");

endmodule : miml_top

/* miml_host_model.sv */
// Host processor model driving the byte-wide register port of miml_top.
// Assumes miml_top takes a strobe on the rising edge; drives on falling.
module miml_host_model (
	input  wire logic       clock_in,
	input  wire logic [7:0] reg_rdata_in,
	output logic      [7:0] reg_addr_out,
	output logic      [7:0] reg_wdata_out,
	output logic            reg_wr_out,
	output logic            reg_rd_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_addr_out  = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
	end

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	// Released data is inverted so a stale byte can never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_in);
		reg_addr_out  = a;
		reg_wdata_out = d;
		reg_wr_out    = 1'b1;
		@(negedge clock_in);
		reg_wr_out    = 1'b0;
		reg_wdata_out = ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock_in);
		reg_addr_out = a;
		reg_rd_out   = 1'b1;
		@(negedge clock_in);
		reg_rd_out   = 1'b0;
		@(negedge clock_in);
		d = reg_rdata_in;
	endtask : rd

endmodule : miml_host_model

/* tb_monitor_interrupt_mask_logic.sv */
// Self-checking bench for miml_top against a byte-level register model.
// Assumes miml_host_model for register access and a short pulse length.
module tb_monitor_interrupt_mask_logic;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned P = 20;

	logic       clock_in, rst_in, reg_wr, reg_rd, temp_alarm, post_wr;
	logic       bot_n, chain_n, intr_in, intr_out, intr_oe, mgmt_n, host_n;
	logic       is_nmi, reset_n, bypass_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg, st1, st2;
	logic [7:0] mk [4];
	logic [4:0] pos_alarm;
	logic [1:0] neg_alarm, sel1, sel2;
	logic [2:0] tach_alarm;
	logic [3:0] voltage_id_inputs, dh, div1, div2;
	logic [31:0] seed;
	int         n_fail, checks_done, i, n;

	miml_top #(.PULSE_CYCLES(P)) u_miml_top (.clock_in(clock_in),
		.rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
		.pos_alarm_in(pos_alarm), .neg_alarm_in(neg_alarm),
		.temp_alarm_in(temp_alarm), .tach_alarm_in(tach_alarm),
		.post_wr_in(post_wr), .board_overtemp_input_n_in(bot_n),
		.chained_mgmt_irq_pin_n_in(chain_n), .voltage_id_inputs_in(voltage_id_inputs),
		.intrusion_in(intr_in), .intrusion_out(intr_out),
		.intrusion_oe_out(intr_oe), .mgmt_irq_output_n_out(mgmt_n),
		.host_irq_n_out(host_n), .host_irq_is_nmi_out(is_nmi),
		.reset_n_out(reset_n), .bypass_n_out(bypass_n),
		.tach1_prescale_select_out(sel1), .tach2_prescale_select_out(sel2),
		.tach1_divisor_out(div1), .tach2_divisor_out(div2));

	miml_host_model u_miml_host_model (.clock_in(clock_in),
		.reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
		.reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));

	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	// ----------------------------------------------------------------
	// Model and checking
	// ----------------------------------------------------------------
	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : xs

	function automatic logic [7:0] expv(input logic [7:0] a);
		case (a)
			8'h40: return cfg;
			8'h41: return st1;
			8'h42: return st2;
			8'h43, 8'h44, 8'h45, 8'h46: return mk[a[1:0] + 2'h1];
			8'h47: return {dh, voltage_id_inputs};
			default: return 8'h00;
		endcase
	endfunction : expv

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test();
		if (n_fail == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		u_miml_host_model.wr(a, d);
		if (a == 8'h40) cfg = d;
		if (a >= 8'h43 && a <= 8'h46) mk[a[1:0] + 2'h1] = d;
		if (a == 8'h47) dh = d[7:4];
	endtask : wreg

	task automatic rreg(input logic [7:0] a);
		logic [7:0] got;
		u_miml_host_model.rd(a, got);
		chk(got, expv(a));
		if (a == 8'h41) st1 = 8'h00;
		if (a == 8'h42) st2 = 8'h00;
	endtask : rreg

	// INT clear in config bit 3 holds both outputs off
	task automatic chk_irq();
		chk({6'h0, mgmt_n, host_n},
			{6'h0, !(cfg[1] && !cfg[3] && |({st1, st2} & ~{mk[0], mk[1]})),
			!(cfg[2] && !cfg[3] && |({st1, st2} & ~{mk[2], mk[3]}))});
	endtask : chk_irq

	task automatic fire(input int k);
		@(negedge clock_in);
		case (k)
			0: pos_alarm[4] = 1'b1;
			1: neg_alarm[0] = 1'b1;
			2: neg_alarm[1] = 1'b1;
			3: tach_alarm[2] = 1'b1;
			4: intr_in = 1'b1;
			5: post_wr = 1'b1;
			6: chain_n = 1'b0;
			default: begin
				pos_alarm[3:0] = 4'hF;
				temp_alarm = 1'b1;
				tach_alarm[1:0] = 2'h3;
				bot_n = 1'b0;
			end
		endcase
		@(negedge clock_in);
		{pos_alarm, neg_alarm, tach_alarm} = '0;
		{temp_alarm, post_wr, intr_in, bot_n} = 4'h1;
	endtask : fire

	// Bounded waits: a missing or endless pulse ends the run
	task automatic pulse(input bit rsel, output int len);
		int k;
		len = 0;
		for (k = 0; k < 20 && !(rsel ? !reset_n : intr_oe); k++)
			@(negedge clock_in);
		while ((rsel ? !reset_n : intr_oe) && len < 1000) begin
			len++;
			chk({7'h0, intr_out}, 8'h00);
			@(negedge clock_in);
		end
		if (k == 20 || len == 1000) begin
			n_fail++;
			end_of_test();
		end
	endtask : pulse

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{n_fail, checks_done} = '0;
		seed = 32'hB42373E3;
		{pos_alarm, neg_alarm, tach_alarm, temp_alarm, post_wr} = '0;
		{bot_n, chain_n, intr_in} = 3'h6;
		voltage_id_inputs = 4'(xs());
		cfg = 8'h08;
		{st1, st2} = '0;
		mk = '{8'h00, 8'h00, 8'h00, 8'h40};
		dh = 4'h5;
		rst_in = 1'b1;
		repeat (10) @(negedge clock_in);
		rst_in = 1'b0;
		repeat (3) @(negedge clock_in);
		for (i = 8'h40; i < 8'h48; i++) rreg(8'(i));
		rreg(8'h50);
		wreg(8'h40, 8'h06);
		fire(7);
		repeat (8) @(negedge clock_in);
		st1 = 8'hFF;
		chk_irq();
		rreg(8'h41);
		for (i = 0; i < 7; i++) begin
			wreg(8'h44, xs() & 8'h7F);
			wreg(8'h46, xs() & 8'h7F);
			if (i == 5) begin
				repeat (31) fire(5);
				repeat (4) @(negedge clock_in);
				rreg(8'h42);
			end
			fire(i);
			repeat (8) @(negedge clock_in);
			st2[i] = 1'b1;
			chk_irq();
			rreg(8'h42);
			repeat (3) @(negedge clock_in);
			chk_irq();
		end
		chain_n = 1'b1;
		for (i = 0; i < 4; i++) begin
			wreg(8'h47, {2'(3 - i), 2'(i), 4'(xs())});
			repeat (2) @(negedge clock_in);
			rreg(8'h47);
			chk({div2, div1}, {4'(1 << (3 - i)), 4'(1 << i)});
			chk({4'h0, sel2, sel1}, {4'h0, 2'(3 - i), 2'(i)});
		end
		wreg(8'h46, mk[3] | 8'h80);
		pulse(1'b0, n);
		chk(8'(n), 8'(P));
		mk[3][7] = 1'b0;
		repeat (3) @(negedge clock_in);
		rreg(8'h46);
		wreg(8'h40, cfg | 8'h10);
		n = 0;
		repeat (30) begin
			@(negedge clock_in);
			if (reset_n !== 1'b1) n++;
		end
		chk(8'(n), 8'h00);
		wreg(8'h44, mk[1] | 8'h80);
		pulse(1'b1, n);
		chk(8'(n), 8'(P));
		cfg[4] = 1'b0;
		repeat (3) @(negedge clock_in);
		rreg(8'h40);
		wreg(8'h40, 8'h26);
		repeat (2) @(negedge clock_in);
		chk({7'h0, is_nmi}, 8'h01);
		// Interrupt clear and bypass, then a soft init back to defaults
		fire(7);
		wreg(8'h40, 8'h4E);
		repeat (8) @(negedge clock_in);
		st1 = 8'hFF;
		chk_irq();
		chk({7'h0, bypass_n}, 8'h00);
		wreg(8'h40, 8'h80);
		{cfg, st1, st2, dh} = {8'h08, 16'h0000, 4'h5};
		mk = '{8'h00, 8'h00, 8'h00, 8'h40};
		repeat (3) @(negedge clock_in);
		chk({6'h0, bypass_n, is_nmi}, 8'h02);
		for (i = 8'h40; i < 8'h48; i++) rreg(8'(i));
		end_of_test();
	end

endmodule : tb_monitor_interrupt_mask_logic
